// file: pkg/dbpe_defs.vh
`ifndef DBPE_DEFS_VH
`define DBPE_DEFS_VH

// Lane geometry
`define DBPE_NUM_LANES     8
`define DBPE_LANE_BITS     6
`define DBPE_PIXEL_BITS    24

// Pixel-mode strap codes, from the two level comparators {above_high, above_low}
`define DBPE_STRAP_SINGLE  2'h0
`define DBPE_STRAP_SPLIT   2'h1
`define DBPE_STRAP_DUAL    2'h3

// Running disparity limits and start value, 6-bit two's complement
`define DBPE_RD_MAX        6'h07
`define DBPE_RD_MIN        6'h3A
`define DBPE_RD_RESET      6'h00

// Synchroniser depth for strap pins
`define DBPE_SYNC_STAGES   2

`endif

// file: verilog/dbpe_lane_balancer.v
`timescale 1ns/100ps
`default_nettype none
`include "dbpe_defs.vh"

module dbpe_lane_balancer #(
  parameter WORD_W = `DBPE_LANE_BITS
) (
  input  wire              ref_clk_in,
  input  wire              arst_n_in,
  input  wire [WORD_W-1:0] word_in,
  input  wire              load_in,
  input  wire              active_in,
  input  wire              balance_in,
  input  wire              lane_on_in,
  output reg  [WORD_W:0]   lane_word_out
);

  localparam [31:0]       WORD_W_32 = WORD_W;
  localparam signed [5:0] WORD_W_S  = WORD_W_32[5:0];
  localparam signed [5:0] ONE_S    = 6'h01;

  reg signed [5:0] rd_q;
  reg signed [5:0] rd_d;
  reg signed [5:0] disp;
  reg signed [5:0] sum;
  reg        [3:0] ones;
  reg              inv;
  integer          i;

  ////////////////////////////////////////////////////////////////////////////
  always @*
  begin
    ones = 4'h0;
    for (i = 0; i < WORD_W; i = i + 1)
      ones = ones + {3'h0, word_in[i]};
    disp = $signed({1'b0, ones, 1'b0}) - WORD_W_S;
    if (rd_q > 6'sd0)
      inv = (disp > 6'sd0);
    else if (rd_q == 6'sd0)
      inv = 1'b1;
    else
      inv = (disp <= 6'sd0);
    if (inv)
      sum = rd_q - disp + ONE_S;
    else
      sum = rd_q + disp - ONE_S;
    // Clamp keeps the sum inside what the receiver tracks
    if (sum > $signed(`DBPE_RD_MAX))
      rd_d = `DBPE_RD_MAX;
    else if (sum < $signed(`DBPE_RD_MIN))
      rd_d = `DBPE_RD_MIN;
    else
      rd_d = sum;
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rd_q          <= `DBPE_RD_RESET;
      lane_word_out <= {(WORD_W+1){1'b0}};
    end
    else if (load_in)
    begin
      if (!lane_on_in)
        lane_word_out <= {(WORD_W+1){1'b0}};
      else if (balance_in && active_in)
      begin
        rd_q          <= rd_d;
        lane_word_out <= {inv, inv ? ~word_in : word_in};
      end
      else
        lane_word_out <= {1'b0, word_in};
    end
  end

endmodule // dbpe_lane_balancer

`default_nettype wire

// file: verilog/dbpe_encoder_top.v
// How it works
// - In split mode the first pixel of a pair goes to the lower four lanes, the next to the upper four.
// - The split pairing restarts on each active edge of the active-video flag (rising when polarity select is high), so it begins odd.
// - The pixel-mode strap selects dual at supply, single at ground and split at mid level.
// - Single mode switches off the upper four lanes and the second link clock.
// - Dual mode drives both link clocks so two separate receivers can be served.
// - With balance on, every enabled lane carries one flag bit per active-video word.
// - A lane word's disparity is its count of ones minus its count of zeros.
// - The running disparity starts within -6..+7 and saturates at those limits.
// - The running sum adds disparity minus one for a true word, one minus disparity if inverted.
// - The flag bit is 0 for a true word and 1 for an inverted word.
// - Positive running disparity with positive word disparity sends the word inverted.
// - Positive running disparity with zero or negative word disparity sends it true.
// - Zero running disparity sends the word inverted.
`timescale 1ns/100ps
`default_nettype none
`include "dbpe_defs.vh"

module dbpe_encoder_top #(
  parameter NUM_LANES = `DBPE_NUM_LANES,
  parameter LANE_W    = `DBPE_LANE_BITS,
  parameter PIX_W     = `DBPE_PIXEL_BITS
) (
  input  wire                          ref_clk_in,
  input  wire                          arst_n_in,
  input  wire [1:0]                    pixel_mode_strap_in,
  input  wire                          enable_polarity_select_in,
  input  wire                          balance_enable_in,
  input  wire                          active_video_flag_in,
  input  wire [2*PIX_W-1:0]            pixel_data_in,
  output wire [NUM_LANES*(LANE_W+1)-1:0] lane_word_out,
  output reg  [NUM_LANES-1:0]          lane_enable_out,
  output reg                           word_valid_out,
  output reg                           word_active_out,
  output reg                           first_link_clock_out,
  output reg                           second_link_clock_out,
  output reg  [1:0]                    mode_out
);

  localparam HALF = NUM_LANES / 2;

  ////////////////////////////////////////////////////////////////////////////
  // Strap synchronisers; straps are pins, so two flops before any use
  reg [1:0] mode_s1_q;
  reg [1:0] mode_s2_q;
  reg       pol_s1_q;
  reg       pol_s2_q;
  reg       dcb_s1_q;
  reg       dcb_s2_q;

  always @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      mode_s1_q <= `DBPE_STRAP_SINGLE;
      mode_s2_q <= `DBPE_STRAP_SINGLE;
      pol_s1_q  <= 1'b1;
      pol_s2_q  <= 1'b1;
      dcb_s1_q  <= 1'b0;
      dcb_s2_q  <= 1'b0;
    end
    else
    begin
      mode_s1_q <= pixel_mode_strap_in;
      mode_s2_q <= mode_s1_q;
      pol_s1_q  <= enable_polarity_select_in;
      pol_s2_q  <= pol_s1_q;
      dcb_s1_q  <= balance_enable_in;
      dcb_s2_q  <= dcb_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode; the unused comparator code 2'h2 falls back to single
  reg is_dual;
  reg is_split;

  always @*
  begin
    is_dual  = 1'b0;
    is_split = 1'b0;
    case (mode_s2_q)
      `DBPE_STRAP_DUAL:   is_dual  = 1'b1;
      `DBPE_STRAP_SPLIT:  is_split = 1'b1;
      `DBPE_STRAP_SINGLE: is_dual  = 1'b0;
      default:            is_dual  = 1'b0;
    endcase
  end

  // Polarity select high means the flag is active high; split relies on it
  wire act = active_video_flag_in ^ ~pol_s2_q;

  ////////////////////////////////////////////////////////////////////////////
  // Split pairing
  reg             act_prev_q;
  reg             phase_q;
  reg             phase_d;
  reg [PIX_W-1:0] odd_pix_q;
  reg [PIX_W-1:0] odd_pix_d;
  reg             odd_act_q;
  reg             odd_act_d;

  reg               emit;
  reg               emit_act;
  reg [2*PIX_W-1:0] emit_data;

  wire act_rise = act & ~act_prev_q;

  always @*
  begin
    emit      = 1'b1;
    emit_act  = act;
    emit_data = pixel_data_in;
    phase_d   = 1'b0;
    odd_pix_d = odd_pix_q;
    odd_act_d = odd_act_q;
    if (is_split)
    begin
      // An odd pixel still pending at the active-video rise is dropped, as the pairing restarts there
      if (act_rise || !phase_q)
      begin
        emit      = 1'b0;
        phase_d   = 1'b1;
        odd_pix_d = pixel_data_in[PIX_W-1:0];
        odd_act_d = act;
      end
      else
      begin
        emit_act  = odd_act_q;
        emit_data = {pixel_data_in[PIX_W-1:0], odd_pix_q};
      end
    end
    else if (!is_dual)
      emit_data = {{PIX_W{1'b0}}, pixel_data_in[PIX_W-1:0]};
  end

  always @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      act_prev_q <= 1'b0;
      phase_q    <= 1'b0;
      odd_pix_q  <= {PIX_W{1'b0}};
      odd_act_q  <= 1'b0;
    end
    else
    begin
      act_prev_q <= act;
      phase_q    <= phase_d;
      odd_pix_q  <= odd_pix_d;
      odd_act_q  <= odd_act_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-lane balance coding
  wire upper_on = is_dual | is_split;

  genvar g;
  generate
    for (g = 0; g < NUM_LANES; g = g + 1)
    begin : g_lane
      dbpe_lane_balancer #(
        .WORD_W (LANE_W)
      ) u_lane (
        .ref_clk_in    (ref_clk_in),
        .arst_n_in     (arst_n_in),
        .word_in       (emit_data[g*LANE_W +: LANE_W]),
        .load_in       (emit),
        .active_in     (emit_act),
        .balance_in    (dcb_s2_q),
        .lane_on_in    ((g < HALF) ? 1'b1 : upper_on),
        .lane_word_out (lane_word_out[g*(LANE_W+1) +: LANE_W+1])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Word strobe, lane enables and link clocks; each clock toggles per word, but single mode holds the second low
  always @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      word_valid_out        <= 1'b0;
      word_active_out       <= 1'b0;
      lane_enable_out       <= {NUM_LANES{1'b0}};
      first_link_clock_out  <= 1'b0;
      second_link_clock_out <= 1'b0;
      mode_out              <= `DBPE_STRAP_SINGLE;
    end
    else
    begin
      word_valid_out  <= emit;
      word_active_out <= emit & emit_act;
      mode_out        <= mode_s2_q;
      lane_enable_out <= {{HALF{upper_on}}, {HALF{1'b1}}};
      if (emit)
        first_link_clock_out <= ~first_link_clock_out;
      // Second clock takes the first one's new phase, so both receivers see one clock
      if (!upper_on)
        second_link_clock_out <= 1'b0;
      else if (emit)
        second_link_clock_out <= ~first_link_clock_out;
    end
  end

endmodule // dbpe_encoder_top

`default_nettype wire

// file: verif/dbpe_encoder_chk.sv
`timescale 1ns/100ps
`default_nettype none
module dbpe_encoder_chk (
  input wire logic        ref_clk_in,
  input wire logic        arst_n_in,
  input wire logic        balance_enable_in,
  input wire logic [55:0] lane_word_out,
  input wire logic [7:0]  lane_enable_out,
  input wire logic        word_valid_out,
  input wire logic        word_active_out,
  input wire logic        first_link_clock_out,
  input wire logic        second_link_clock_out,
  input wire logic [1:0]  mode_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);
  a_blank_flags: assert property (word_valid_out
    && !(word_active_out && balance_enable_in)
    |-> (lane_word_out & {8{7'h40}}) == 56'h0) else $error("flag outside balanced video");
  a_split_gap: assert property (mode_out == 2'h1 && word_valid_out |=> !word_valid_out)
    else $error("split words back to back");
  a_split_flow: assert property (mode_out == 2'h1 && !word_valid_out
    |-> ##[1:3] word_valid_out) else $error("split stream stalled");
  a_active_valid: assert property (word_active_out |-> word_valid_out)
    else $error("active flag without word");
  a_clk_per_word: assert property ($changed(first_link_clock_out) == word_valid_out)
    else $error("link clock out of step with words");
  a_single_off: assert property (!mode_out[0] && !$past(mode_out[0])
    |-> !second_link_clock_out && lane_enable_out[7:4] == 4'h0 && lane_word_out[55:28] == 28'h0)
    else $error("upper half active in single");
  a_dual_clks: assert property (mode_out == 2'h3 && $past(mode_out, 2) == 2'h3
    |-> second_link_clock_out == first_link_clock_out && lane_enable_out == 8'hFF)
    else $error("dual outputs wrong");
  a_dual_stream: assert property (mode_out == 2'h3 && $past(mode_out, 2) == 2'h3
    |-> word_valid_out) else $error("dual missed a word");
  c_split_video: cover property (mode_out == 2'h1 && word_active_out);
  c_inverted: cover property (word_active_out && (lane_word_out & {8{7'h40}}) != 56'h0);
  c_single_video: cover property (!mode_out[0] && word_active_out);
endmodule // dbpe_encoder_chk
bind dbpe_encoder_top dbpe_encoder_chk i_chk (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
  .balance_enable_in(balance_enable_in), .lane_word_out(lane_word_out),
  .lane_enable_out(lane_enable_out), .word_valid_out(word_valid_out),
  .word_active_out(word_active_out), .first_link_clock_out(first_link_clock_out),
  .second_link_clock_out(second_link_clock_out), .mode_out(mode_out));
`default_nettype wire

// file: verif/dbpe_rx_model.sv
`timescale 1ns/100ps
`default_nettype none
module dbpe_rx_model (
  input  wire logic [55:0] lane_word_in,
  input  wire logic        balance_enable_in,
  output var  logic [47:0] pixel_out
);
  // Flags are ignored when strapped off, as a legacy-facing receiver would
  always_comb
    for (int k = 0; k < 8; k++)
      pixel_out[6*k+:6] = lane_word_in[7*k+:6] ^ {6{balance_enable_in & lane_word_in[7*k+6]}};
endmodule // dbpe_rx_model
`default_nettype wire

// file: verif/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic         clk = 1'b0;
  logic         arst_n = 1'b0;
  logic [1:0]   strap = 2'h0;
  logic         eps = 1'b1;
  logic         dcb = 1'b0;
  logic         act = 1'b0;
  logic [47:0]  pix = 48'h0;
  wire  [55:0]  lanes;
  wire  [7:0]   en;
  wire          vld, wact, c1, c2;
  wire  [1:0]   md_o;
  wire  [47:0]  rx_d;
  int           error_cnt = 0;
  int           checks_done = 0;
  int           cyc = 0;
  int           rd[8];
  int           due[$];
  logic [104:0] q[$];
  logic [23:0]  hold;
  logic         ph, pa;
  logic [1:0]   md;
  always #25 clk = ~clk;
  dbpe_encoder_top i_dut (.ref_clk_in(clk), .arst_n_in(arst_n), .pixel_mode_strap_in(strap),
    .enable_polarity_select_in(eps), .balance_enable_in(dcb), .active_video_flag_in(act),
    .pixel_data_in(pix), .lane_word_out(lanes), .lane_enable_out(en), .word_valid_out(vld),
    .word_active_out(wact), .first_link_clock_out(c1), .second_link_clock_out(c2),
    .mode_out(md_o));
  dbpe_rx_model i_rx (.lane_word_in(lanes), .balance_enable_in(dcb), .pixel_out(rx_d));
  //////////////////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [56:0] seen, input logic [56:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Reference coder; rd only moves on balanced video words
  function automatic [55:0] enc(input [47:0] d, input a);
    int o;
    for (int k = 0; k < 8; k++)
    begin
      o = $countones(d[6*k+:6]) * 2 - 6;
      enc[7*k+:7] = {1'b0, d[6*k+:6]};
      if (md == 2'h0 && k > 3)
        enc[7*k+:7] = 7'h00;
      else if (a && dcb && (rd[k] > 0 ? o > 0 : (rd[k] == 0 || o <= 0)))
      begin
        enc[7*k+:7] = {1'b1, ~d[6*k+:6]};
        rd[k] = rd[k] + 1 - o;
      end
      else if (a && dcb)
        rd[k] = rd[k] + o - 1;
      rd[k] = rd[k] > 7 ? 7 : (rd[k] < -6 ? -6 : rd[k]);
    end
  endfunction
  function automatic void push(input [47:0] w, input a);
    q.push_back({a, enc(w, a), w});
    due.push_back(cyc + 2);
  endfunction
  task automatic px(input [47:0] d, input a);
    @(posedge clk);
    pix <= d;
    act <= a ~^ eps;
    if (a && !pa)
      ph = 1'b0;
    if (md != 2'h1)
      push(md == 2'h0 ? {24'h0, d[23:0]} : d, a);
    else
    begin
      // A split word is active when its odd (earlier) pixel was
      if (ph)
        push({d[23:0], hold}, pa);
      hold = d[23:0];
      ph = !ph;
    end
    pa = a;
  endtask
  task automatic run(input [1:0] m, input b, input e);
    @(posedge clk);
    arst_n <= 1'b0;
    strap <= m;
    dcb <= b;
    eps <= e;
    act <= ~e;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    md = m[0] ? m : 2'h0;
    ph = 1'b0;
    pa = 1'b0;
    q.delete();
    due.delete();
    foreach (rd[k]) rd[k] = 0;
    chk("mode", 57'(md_o), 57'(m));
    // Both link clocks share one phase whenever the upper half is on
    chk("enables", 57'({c2, en}), m[0] ? 57'({c1, 8'hFF}) : 57'h0F);
    for (int i = 0; i < 16; i++) px(i * 48'h3A5C_6F0E_91B7, i < 12);
    for (int i = 0; i < 10 && q.size() > 0; i++) @(posedge clk);
    chk("drained", 57'(q.size()), 57'h0);
  endtask
  //////////////////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (vld === 1'b1 && q.size() > 0 && cyc >= due[0])
    begin
      chk("lane words", {wact, lanes}, q[0][104:48]);
      chk("decoded", 57'(rx_d), 57'(q[0][47:0]));
      void'(q.pop_front());
      void'(due.pop_front());
    end
  end
  initial
  begin
    run(2'h3, 1'b1, 1'b1);
    run(2'h3, 1'b1, 1'b0);
    run(2'h2, 1'b1, 1'b1);
    run(2'h0, 1'b1, 1'b0);
    run(2'h1, 1'b1, 1'b1);
    run(2'h1, 1'b0, 1'b1);
    end_sim;
  end
  initial
  begin
    #1000000;
    error_cnt++;
    end_sim;
  end
endmodule // tb
`default_nettype wire
